// [inc/afe_defines.svh]
// Purpose: constants of the battery monitor control and configuration registers
// Assumes: 10 MHz register clock, byte wide register map
// Notes: times are kept in their own unit, cycle counts are derived from them
// Contract
// R1: four retained read/write general purpose flags
// R2: mux select codes route cells and temperatures
// R3: force-sleep write enters sleep, regulator off
// R4: force-sleep clears itself on wake
// R5: sleep leaves mux select unchanged
// R6: auto scan powers sensor 5ms each 640ms
// R7: regulator disable bit turns regulator off
// R8: sensor supply force-on holds supply on
// R9: force reset bit clears all registers
// R10: wake pin disable blocks pin wake
// R11: wake polarity picks rising or falling edge
// R12: write guard gates feature register writes
// R13: registers retained on cell power during sleep
// R14: force-sleep cleared by power-up, wake, write
// R15: wait 1ms after supply on before comparing
// R16: host writes zeros, avoids reserved addresses
// R17: reserved reads zero, writes on register clock
`ifndef AFE_DEFINES_SVH
`define AFE_DEFINES_SVH

// ==========================================================
// register offsets
`define AFE_OFS_SEL        8'h03
`define AFE_OFS_CTL        8'h04
`define AFE_OFS_FEAT       8'h07
`define AFE_OFS_GUARD      8'h08

// ==========================================================
// writable bits and field positions
`define AFE_MASK_SEL       8'hCF
`define AFE_MASK_CTL       8'h80
`define AFE_MASK_FEAT      8'hE3
`define AFE_MASK_GUARD     8'h98
`define AFE_RST_VAL        8'h00
`define AFE_BIT_SLEEP      7
`define AFE_BIT_AUTO_OFF   7
`define AFE_BIT_REG_DIS    6
`define AFE_BIT_FORCE_ON   5
`define AFE_BIT_POR        2
`define AFE_BIT_WAKE_DIS   1
`define AFE_BIT_WAKE_POL   0
`define AFE_BIT_GUARD      7
`define AFE_MUX_EXT_TEMP   4'h8
`define AFE_MUX_LAST       4'h9

// ==========================================================
// timing
`define AFE_MCLK_NS        100
`define AFE_SCAN_PERIOD_MS 640
`define AFE_SCAN_ON_MS     5
`define AFE_SETTLE_MS      1
`define AFE_SCAN_PERIOD_CYC ((`AFE_SCAN_PERIOD_MS * 1000000) / `AFE_MCLK_NS)
`define AFE_SCAN_ON_CYC    ((`AFE_SCAN_ON_MS * 1000000) / `AFE_MCLK_NS)
`define AFE_SETTLE_CYC     ((`AFE_SETTLE_MS * 1000000 + `AFE_MCLK_NS - 1) / `AFE_MCLK_NS)

`endif

// [inc/afe_pkg.sv]
// Purpose: types shared by the register bank and its clock crossing
// Assumes: afe_defines.svh holds all numbers
// Notes: none
package afe_pkg;

  // ==========================================================
  // one register write carried from the serial side
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] data;
  } afe_wr_s;

  // ==========================================================
  // register image mirrored to the serial side for reads
  typedef struct packed {
    logic [7:0] sel;
    logic [7:0] ctl;
    logic [7:0] feat;
    logic [7:0] guard;
  } afe_rb_s;

  // ==========================================================
  // serial slave states
  typedef enum logic [8:0] {
    AFE_IDLE  = 9'h001,
    AFE_ADDR  = 9'h002,
    AFE_ACK_A = 9'h004,
    AFE_PTR   = 9'h008,
    AFE_ACK_P = 9'h010,
    AFE_WDATA = 9'h020,
    AFE_ACK_W = 9'h040,
    AFE_RDATA = 9'h080,
    AFE_ACK_R = 9'h100
  } afe_i2c_e;

endpackage : afe_pkg

// [logic/afe_word_sync.sv]
// Purpose: moves one word between two clock domains by toggle handshake
// Assumes: source waits while busy; data held until acknowledged
// Notes: destination data and valid come from flip-flops
`timescale 1ns/10ps
module afe_word_sync #(
  parameter int W = 16
) (
  input  wire logic         src_clk,
  input  wire logic         src_rst_n,
  input  wire logic         src_valid,
  input  wire logic [W-1:0] src_data,
  output logic              src_busy,
  input  wire logic         dst_clk,
  input  wire logic         dst_rst_n,
  output logic              dst_valid,
  output logic [W-1:0]      dst_data
);
  logic         req_q;
  logic [W-1:0] hold_q;
  logic         ack_m_q;
  logic         ack_s_q;
  logic         req_m_q;
  logic         req_s_q;
  logic         ack_q;

  // ==========================================================
  // source side
  assign src_busy = req_q ^ ack_s_q;

  always_ff @(posedge src_clk or negedge src_rst_n) begin
    if (!src_rst_n) begin
      req_q  <= 1'b0;
      hold_q <= '0;
    end else if (src_valid && !src_busy) begin
      req_q  <= ~req_q;
      hold_q <= src_data;
    end
  end

  always_ff @(posedge src_clk or negedge src_rst_n) begin
    if (!src_rst_n) begin
      ack_m_q <= 1'b0;
      ack_s_q <= 1'b0;
    end else begin
      ack_m_q <= ack_q;
      ack_s_q <= ack_m_q;
    end
  end

  // ==========================================================
  // destination side; hold_q is stable while the toggle travels
  always_ff @(posedge dst_clk or negedge dst_rst_n) begin
    if (!dst_rst_n) begin
      req_m_q   <= 1'b0;
      req_s_q   <= 1'b0;
      ack_q     <= 1'b0;
      dst_valid <= 1'b0;
      dst_data  <= '0;
    end else begin
      req_m_q   <= req_q;
      req_s_q   <= req_m_q;
      dst_valid <= req_s_q ^ ack_q;
      if (req_s_q ^ ack_q) begin
        ack_q    <= req_s_q;
        dst_data <= hold_q;
      end
    end
  end

endmodule : afe_word_sync

// [logic/afe_regs.sv]
// Purpose: control and configuration registers of a battery monitor front end
// Assumes: serial slave runs on lclk, registers and timers on mclk
// Notes: sleep does not reset the register bank, only nrst and force reset do
`timescale 1ns/10ps
`include "afe_defines.svh"
module afe_regs
  import afe_pkg::*;
#(
  parameter logic [6:0] SLAVE_ADDR      = 7'h2A,
  parameter int         SCAN_PERIOD_CYC = `AFE_SCAN_PERIOD_CYC,
  parameter int         SCAN_ON_CYC     = `AFE_SCAN_ON_CYC,
  parameter int         SETTLE_CYC      = `AFE_SETTLE_CYC
) (
  input  wire logic       mclk,
  input  wire logic       nrst,
  input  wire logic       lclk,
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  output logic            sda_o,
  output logic            sda_oe,
  input  wire logic       wake_pin,
  input  wire logic       temp_below_ref,
  output logic [3:0]      mux_select_field,
  output logic            analog_monitor_out,
  output logic            regulator_output,
  output logic            sensor_supply_output,
  output logic            storage_from_cell,
  output logic            sleep_state,
  output logic            ext_overtemp
);

  localparam int CW = $clog2(SCAN_PERIOD_CYC + 1);
  localparam int SW = $clog2(SETTLE_CYC + 1);

  if (SCAN_ON_CYC < 1 || SCAN_ON_CYC >= SCAN_PERIOD_CYC || SETTLE_CYC < 1) begin : g_chk
    $error("afe_regs: scan or settle counts out of range");
  end

  // ==========================================================
  // serial side declarations
  afe_i2c_e   st_q;
  logic       scl_m_q;
  logic       scl_s_q;
  logic       scl_d_q;
  logic       sda_m_q;
  logic       sda_s_q;
  logic       sda_d_q;
  logic [7:0] sh_q;
  logic [7:0] tx_q;
  logic [7:0] ptr_q;
  logic [3:0] cnt_q;
  logic       rw_q;
  logic       mack_q;
  logic       wr_pulse_q;
  afe_wr_s    wr_req_q;
  afe_rb_s    rb_l;
  logic       rb_l_vld;
  logic       scl_rise;
  logic       scl_fall;
  logic       start_c;
  logic       stop_c;

  // ==========================================================
  // register side declarations
  afe_wr_s    wr_m;
  logic       wr_m_vld;
  logic       wr_busy;
  logic       rb_busy;
  afe_rb_s    rb_m;
  logic [7:0] sel_q;
  logic [7:0] ctl_q;
  logic [7:0] feat_q;
  logic [7:0] guard_q;
  logic       wake_m_q;
  logic       wake_s_q;
  logic       wake_d_q;
  logic       tmp_m_q;
  logic       tmp_s_q;
  logic       wake_ev;
  logic       por_wr;
  logic       feat_wr_ok;
  logic [CW-1:0] scan_cnt_q;
  logic [SW-1:0] settle_q;
  logic       scan_on;
  logic       supply_d;

  // ==========================================================
  // pin synchronisers on the link clock
  always_ff @(posedge lclk or negedge nrst) begin
    if (!nrst) begin
      scl_m_q <= 1'b1;
      scl_s_q <= 1'b1;
      scl_d_q <= 1'b1;
      sda_m_q <= 1'b1;
      sda_s_q <= 1'b1;
      sda_d_q <= 1'b1;
    end else begin
      scl_m_q <= scl_i;
      scl_s_q <= scl_m_q;
      scl_d_q <= scl_s_q;
      sda_m_q <= sda_i;
      sda_s_q <= sda_m_q;
      sda_d_q <= sda_s_q;
    end
  end

  assign scl_rise = scl_s_q && !scl_d_q;
  assign scl_fall = !scl_s_q && scl_d_q;
  assign start_c  = scl_s_q && scl_d_q && sda_d_q && !sda_s_q;
  assign stop_c   = scl_s_q && scl_d_q && !sda_d_q && sda_s_q;

  // unmapped offsets and status registers read as zero
  function automatic logic [7:0] rd_byte(input logic [7:0] a, input afe_rb_s r);
    logic [7:0] v;
    v = 8'h00;
    case (a)
      `AFE_OFS_SEL:   v = r.sel;
      `AFE_OFS_CTL:   v = r.ctl;
      `AFE_OFS_FEAT:  v = r.feat;
      `AFE_OFS_GUARD: v = r.guard;
      default:        v = 8'h00;
    endcase
    return v;
  endfunction : rd_byte

  // ==========================================================
  // serial slave state machine
  always_ff @(posedge lclk or negedge nrst) begin
    if (!nrst) begin
      st_q       <= AFE_IDLE;
      sh_q       <= 8'h00;
      tx_q       <= 8'h00;
      ptr_q      <= 8'h00;
      cnt_q      <= 4'h0;
      rw_q       <= 1'b0;
      mack_q     <= 1'b0;
      wr_pulse_q <= 1'b0;
      wr_req_q   <= '0;
    end else begin
      wr_pulse_q <= 1'b0;
      if (start_c) begin
        st_q  <= AFE_ADDR;
        cnt_q <= 4'h0;
      end else if (stop_c) begin
        st_q <= AFE_IDLE;
      end else begin
        unique case (st_q)
          AFE_IDLE: begin
            cnt_q <= 4'h0;
          end
          AFE_ADDR, AFE_PTR, AFE_WDATA: begin
            if (scl_rise) begin
              sh_q  <= {sh_q[6:0], sda_s_q};
              cnt_q <= cnt_q + 4'h1;
            end else if (scl_fall && cnt_q == 4'h8) begin
              cnt_q <= 4'h0;
              if (st_q == AFE_ADDR) begin
                if (sh_q[7:1] == SLAVE_ADDR) begin
                  rw_q <= sh_q[0];
                  st_q <= AFE_ACK_A;
                end else begin
                  st_q <= AFE_IDLE;
                end
              end else if (st_q == AFE_PTR) begin
                ptr_q <= sh_q;
                st_q  <= AFE_ACK_P;
              end else begin
                // R17 write handed to register clock
                wr_pulse_q    <= 1'b1;
                wr_req_q.addr <= ptr_q;
                wr_req_q.data <= sh_q;
                ptr_q         <= ptr_q + 8'h01;
                st_q          <= AFE_ACK_W;
              end
            end
          end
          AFE_ACK_A: begin
            if (scl_fall) begin
              if (rw_q) begin
                tx_q  <= rd_byte(ptr_q, rb_l);
                ptr_q <= ptr_q + 8'h01;
                st_q  <= AFE_RDATA;
              end else begin
                st_q <= AFE_PTR;
              end
            end
          end
          AFE_ACK_P, AFE_ACK_W: begin
            if (scl_fall) begin
              st_q <= AFE_WDATA;
            end
          end
          AFE_RDATA: begin
            if (scl_fall) begin
              if (cnt_q == 4'h7) begin
                cnt_q <= 4'h0;
                st_q  <= AFE_ACK_R;
              end else begin
                tx_q  <= {tx_q[6:0], 1'b0};
                cnt_q <= cnt_q + 4'h1;
              end
            end
          end
          AFE_ACK_R: begin
            if (scl_rise) begin
              mack_q <= !sda_s_q;
            end else if (scl_fall) begin
              if (mack_q) begin
                tx_q  <= rd_byte(ptr_q, rb_l);
                ptr_q <= ptr_q + 8'h01;
                st_q  <= AFE_RDATA;
              end else begin
                st_q <= AFE_IDLE;
              end
            end
          end
        endcase
      end
    end
  end

  // open drain: only ever pulls low
  assign sda_o  = 1'b0;
  assign sda_oe = (st_q == AFE_ACK_A) || (st_q == AFE_ACK_P) || (st_q == AFE_ACK_W)
                || ((st_q == AFE_RDATA) && !tx_q[7]);

  // ==========================================================
  // clock crossings: writes inward, register image outward
  afe_word_sync #(.W(16)) u_wr_sync (
    .src_clk   (lclk),
    .src_rst_n (nrst),
    .src_valid (wr_pulse_q),
    .src_data  (wr_req_q),
    .src_busy  (wr_busy),
    .dst_clk   (mclk),
    .dst_rst_n (nrst),
    .dst_valid (wr_m_vld),
    .dst_data  (wr_m)
  );

  // R17 reserved bits read back as zero
  assign rb_m = '{sel: sel_q, ctl: ctl_q, feat: feat_q, guard: guard_q};

  afe_word_sync #(.W(32)) u_rb_sync (
    .src_clk   (mclk),
    .src_rst_n (nrst),
    .src_valid (1'b1),
    .src_data  (rb_m),
    .src_busy  (rb_busy),
    .dst_clk   (lclk),
    .dst_rst_n (nrst),
    .dst_valid (rb_l_vld),
    .dst_data  (rb_l)
  );

  // ==========================================================
  // pin synchronisers on the register clock
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      wake_m_q <= 1'b0;
      wake_s_q <= 1'b0;
      wake_d_q <= 1'b0;
      tmp_m_q  <= 1'b0;
      tmp_s_q  <= 1'b0;
    end else begin
      wake_m_q <= wake_pin;
      wake_s_q <= wake_m_q;
      wake_d_q <= wake_s_q;
      tmp_m_q  <= temp_below_ref;
      tmp_s_q  <= tmp_m_q;
    end
  end

  // R11 edge chosen by polarity
  // R10 pin ignored while disabled
  assign wake_ev = ctl_q[`AFE_BIT_SLEEP] && !feat_q[`AFE_BIT_WAKE_DIS]
                 && (feat_q[`AFE_BIT_WAKE_POL] ? (wake_s_q && !wake_d_q)
                                                : (!wake_s_q && wake_d_q));

  // R12 feature writes need the guard
  assign feat_wr_ok = wr_m_vld && wr_m.addr == `AFE_OFS_FEAT && guard_q[`AFE_BIT_GUARD];
  // R9 forced reset request
  assign por_wr     = feat_wr_ok && wr_m.data[`AFE_BIT_POR];

  // ==========================================================
  // register bank; kept through sleep as it runs from cell power
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      sel_q   <= `AFE_RST_VAL;
      ctl_q   <= `AFE_RST_VAL;
      feat_q  <= `AFE_RST_VAL;
      guard_q <= `AFE_RST_VAL;
    end else if (por_wr) begin
      // R9 clear every register
      sel_q   <= `AFE_RST_VAL;
      ctl_q   <= `AFE_RST_VAL;
      feat_q  <= `AFE_RST_VAL;
      guard_q <= `AFE_RST_VAL;
    end else begin
      // R1 flags a and b with mux select
      // R2 select field stored as written
      if (wr_m_vld && wr_m.addr == `AFE_OFS_SEL) begin
        sel_q <= wr_m.data & `AFE_MASK_SEL;
      end
      // R3 write one enters sleep
      // R14 write zero leaves sleep
      if (wr_m_vld && wr_m.addr == `AFE_OFS_CTL) begin
        ctl_q <= wr_m.data & `AFE_MASK_CTL;
      end else if (wake_ev) begin
        // R4 self clear on wake
        ctl_q[`AFE_BIT_SLEEP] <= 1'b0;
      end
      // R12 guarded feature write
      if (feat_wr_ok) begin
        feat_q <= wr_m.data & `AFE_MASK_FEAT;
      end
      // R1 flags c and d with guard bit
      if (wr_m_vld && wr_m.addr == `AFE_OFS_GUARD) begin
        guard_q <= wr_m.data & `AFE_MASK_GUARD;
      end
    end
  end

  // ==========================================================
  // automatic temperature scan
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      scan_cnt_q <= '0;
    end else if (feat_q[`AFE_BIT_AUTO_OFF]) begin
      scan_cnt_q <= '0;
    end else if (scan_cnt_q == CW'(SCAN_PERIOD_CYC - 1)) begin
      scan_cnt_q <= '0;
    end else begin
      scan_cnt_q <= scan_cnt_q + CW'(1);
    end
  end

  // R6 on window at start of period
  assign scan_on  = !feat_q[`AFE_BIT_AUTO_OFF] && (scan_cnt_q < CW'(SCAN_ON_CYC));
  // R8 force-on overrides scan timing
  assign supply_d = feat_q[`AFE_BIT_FORCE_ON] || scan_on
                  || (sel_q[3:0] == `AFE_MUX_EXT_TEMP);

  // ==========================================================
  // sensor supply and over-temperature compare
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      sensor_supply_output <= 1'b0;
      settle_q             <= '0;
      ext_overtemp         <= 1'b0;
    end else begin
      sensor_supply_output <= supply_d;
      // R15 settle count from supply on
      if (!sensor_supply_output) begin
        settle_q <= '0;
      end else if (settle_q != SW'(SETTLE_CYC)) begin
        settle_q <= settle_q + SW'(1);
      end
      ext_overtemp <= sensor_supply_output && settle_q == SW'(SETTLE_CYC) && tmp_s_q;
    end
  end

  // ==========================================================
  // outputs toward the analog section
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      mux_select_field   <= 4'h0;
      analog_monitor_out <= 1'b0;
      regulator_output   <= 1'b0;
      storage_from_cell  <= 1'b0;
      sleep_state        <= 1'b0;
    end else begin
      // R5 select held through sleep
      mux_select_field   <= sel_q[3:0];
      // R2 zero and reserved codes drive nothing
      analog_monitor_out <= sel_q[3:0] != 4'h0 && sel_q[3:0] <= `AFE_MUX_LAST
                          && !ctl_q[`AFE_BIT_SLEEP];
      // R3 regulator off in sleep
      // R7 regulator off when disabled
      regulator_output   <= !ctl_q[`AFE_BIT_SLEEP] && !feat_q[`AFE_BIT_REG_DIS];
      // R13 storage moves to cell power
      storage_from_cell  <= ctl_q[`AFE_BIT_SLEEP];
      sleep_state        <= ctl_q[`AFE_BIT_SLEEP];
    end
  end

endmodule : afe_regs

// [tb/afe_regs_props.sv]
// Purpose: port checker for the register bank
// Assumes: one mclk domain
// Notes: bound from the foot of this file
`timescale 1ns/10ps
module afe_regs_props #(
  parameter int SETTLE_CYC = 5
) (
  input wire logic       mclk,
  input wire logic       nrst,
  input wire logic       temp_below_ref,
  input wire logic [3:0] mux_select_field,
  input wire logic       analog_monitor_out,
  input wire logic       regulator_output,
  input wire logic       sensor_supply_output,
  input wire logic       storage_from_cell,
  input wire logic       sleep_state,
  input wire logic       ext_overtemp
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  // ==========================================================
  // cycles the supply has stood on
  int unsigned on_cnt_q;
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      on_cnt_q <= 0;
    end else if (sensor_supply_output) begin
      on_cnt_q <= (on_cnt_q < 1000) ? on_cnt_q + 1 : on_cnt_q;
    end else begin
      on_cnt_q <= 0;
    end
  end

  // ==========================================================
  // properties
  sequence enter_sleep;
    !sleep_state ##1 sleep_state;
  endsequence

  sleep_reg_a: assert property (sleep_state && $past(sleep_state) |-> !regulator_output)
    else $error("regulator on while asleep");
  sleep_mon_a: assert property (sleep_state && $past(sleep_state) |-> !analog_monitor_out)
    else $error("monitor on while asleep");
  storage_a: assert property (storage_from_cell == sleep_state)
    else $error("storage not following sleep");
  mux_hold_a: assert property (enter_sleep |-> $stable(mux_select_field))
    else $error("mux select changed on sleep entry");
  mon_code_a: assert property (analog_monitor_out && $stable(mux_select_field)
    && $stable(sleep_state) |-> !sleep_state && mux_select_field inside {[4'h1:4'h9]})
    else $error("monitor on for idle or reserved code");
  supply_sel_a: assert property (mux_select_field == 4'h8 && $past(mux_select_field) == 4'h8
    |-> sensor_supply_output)
    else $error("supply off with external temp selected");
  ot_settle_a: assert property (ext_overtemp |-> $past(on_cnt_q) >= SETTLE_CYC - 1)
    else $error("overtemp before supply settled");
  ot_cause_a: assert property ($rose(ext_overtemp) |-> $past(temp_below_ref, 2)
    || $past(temp_below_ref, 3) || $past(temp_below_ref, 4) || $past(temp_below_ref, 5))
    else $error("overtemp without comparator");
endmodule : afe_regs_props

bind afe_regs afe_regs_props #(.SETTLE_CYC(SETTLE_CYC)) afe_regs_props_i (
  .mclk(mclk), .nrst(nrst), .temp_below_ref(temp_below_ref),
  .mux_select_field(mux_select_field), .analog_monitor_out(analog_monitor_out),
  .regulator_output(regulator_output), .sensor_supply_output(sensor_supply_output),
  .storage_from_cell(storage_from_cell), .sleep_state(sleep_state),
  .ext_overtemp(ext_overtemp));

// [tb/afe_host_model.sv]
// Purpose: two-wire bus master for the pack controller
// Assumes: pull-up on the data line; scl driven high and low by this model
// Notes: scl half period 2*Q mclk cycles
`timescale 1ns/10ps
module afe_host_model #(
  parameter logic [6:0] DEV_ADDR = 7'h2A,
  parameter int         Q        = 5
) (
  input  wire logic mclk,
  input  wire logic sda_line,
  output logic      scl,
  output logic      sda_low
);
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask : tick

  // ==========================================================
  // start also serves as repeated start
  task automatic go_start();
    tick(1);
    sda_low <= 1'b0;
    tick(Q);
    scl <= 1'b1;
    tick(Q);
    sda_low <= 1'b1;
    tick(Q);
    scl <= 1'b0;
    tick(Q);
  endtask : go_start

  task automatic go_stop();
    sda_low <= 1'b1;
    tick(Q);
    scl <= 1'b1;
    tick(Q);
    sda_low <= 1'b0;
    tick(4 * Q);
  endtask : go_stop

  // data set while scl low, sampled mid scl high
  task automatic one_bit(input logic b, output logic r);
    sda_low <= ~b;
    tick(Q);
    scl <= 1'b1;
    tick(Q);
    r = sda_line;
    tick(Q);
    scl <= 1'b0;
    tick(Q);
  endtask : one_bit

  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      one_bit(tx[i], r);
      rx[i] = r;
    end
    one_bit(1'b1, r);
    ack = ~r;
  endtask : xfer

  // ==========================================================
  // only mapped offsets written, by the caller
  task automatic wr(input logic [7:0] ptr, input logic [7:0] d, output logic ok);
    logic [7:0] rx;
    logic       a0, a1, a2;
    go_start();
    xfer({DEV_ADDR, 1'b0}, rx, a0);
    xfer(ptr, rx, a1);
    xfer(d, rx, a2);
    go_stop();
    ok = a0 & a1 & a2;
  endtask : wr

  // last byte closed with a nack
  task automatic rd(input logic [7:0] ptr, output logic [7:0] d, output logic ok);
    logic [7:0] rx;
    logic       a0, a1, a2, na;
    go_start();
    xfer({DEV_ADDR, 1'b0}, rx, a0);
    xfer(ptr, rx, a1);
    go_start();
    xfer({DEV_ADDR, 1'b1}, rx, a2);
    xfer(8'hFF, d, na);
    go_stop();
    ok = a0 & a1 & a2;
  endtask : rd
endmodule : afe_host_model

// [tb/tb_top.sv]
// Purpose: self-checking bench for the register bank
// Assumes: shortened scan and settle counts
// Notes: registers reached over the two-wire bus
`timescale 1ns/10ps
module tb_top;
  localparam int SCAN_P  = 200;
  localparam int SCAN_ON = 20;
  localparam logic [7:0] OFFS [5] = '{8'h03, 8'h04, 8'h07, 8'h08, 8'h09};
  localparam logic [3:0] CODES [7] = '{4'h0, 4'h1, 4'h7, 4'h8, 4'h9, 4'hA, 4'hC};
  localparam logic       MON [7]   = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0};

  logic       mclk = 1'b0;
  logic       lclk = 1'b0;
  logic       nrst = 1'b0;
  logic       wake_pin = 1'b1;
  logic       temp_below_ref = 1'b0;
  logic       scl, sda_low, sda_o, sda_oe, sda_line, ok;
  logic [3:0] mux_select_field;
  logic       analog_monitor_out, regulator_output, sensor_supply_output;
  logic       storage_from_cell, sleep_state, ext_overtemp;
  logic [7:0] rdat;
  int         errors = 0;
  int         num_checks = 0;

  always #50 mclk = ~mclk;
  always #62.5 lclk = ~lclk;
  // open drain with pull-up
  assign sda_line = ~sda_low & (sda_oe ? sda_o : 1'b1);

  afe_regs #(.SCAN_PERIOD_CYC(SCAN_P), .SCAN_ON_CYC(SCAN_ON), .SETTLE_CYC(5)) afe_regs_i (
    .mclk(mclk), .nrst(nrst), .lclk(lclk), .scl_i(scl), .sda_i(sda_line), .sda_o(sda_o),
    .sda_oe(sda_oe), .wake_pin(wake_pin), .temp_below_ref(temp_below_ref),
    .mux_select_field(mux_select_field), .analog_monitor_out(analog_monitor_out),
    .regulator_output(regulator_output), .sensor_supply_output(sensor_supply_output),
    .storage_from_cell(storage_from_cell), .sleep_state(sleep_state),
    .ext_overtemp(ext_overtemp));

  afe_host_model #(.DEV_ADDR(7'h2A)) afe_host_model_i (
    .mclk(mclk), .sda_line(sda_line), .scl(scl), .sda_low(sda_low));

  // ==========================================================
  // tasks
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t ns: %s got %h want %h", $time, what, got, exp);
    end
  endtask : chk8

  task automatic chkn(input int got, input int exp, input string what);
    num_checks++;
    if (got != exp) begin
      errors++;
      $display("unexpected at %0t ns: %s got %0d want %0d", $time, what, got, exp);
    end
  endtask : chkn

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : cyc

  task automatic flag(input logic got, input logic exp, input string what);
    chk8({7'h00, got}, {7'h00, exp}, what);
  endtask : flag

  task automatic wr_c(input logic [7:0] ptr, input logic [7:0] d);
    afe_host_model_i.wr(ptr, d, ok);
    cyc(2);
    flag(ok, 1'b1, "write ack");
  endtask : wr_c

  task automatic rd_c(input logic [7:0] ptr, input logic [7:0] exp);
    afe_host_model_i.rd(ptr, rdat, ok);
    flag(ok, 1'b1, "read ack");
    chk8(rdat, exp, "readback");
  endtask : rd_c

  task automatic count_on(input int n, input int exp);
    int c = 0;
    repeat (n) begin
      cyc(1);
      c += int'(sensor_supply_output === 1'b1);
    end
    chkn(c, exp, "supply cycles");
  endtask : count_on

  task automatic pin(input logic v);
    @(posedge mclk);
    wake_pin <= v;
    cyc(10);
  endtask : pin

  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : close_out

  // ==========================================================
  // watchdog and tests
  initial begin
    repeat (100000) @(posedge mclk);
    errors++;
    $display("unexpected at %0t ns: timeout", $time);
    close_out();
  end

  initial begin
    repeat (8) @(posedge mclk);
    nrst <= 1'b1;
    cyc(20);
    flag(sleep_state, 1'b0, "awake after reset");
    foreach (OFFS[i]) rd_c(OFFS[i], 8'h00);
    $display("test reset done");
    foreach (CODES[i]) begin
      wr_c(8'h03, {4'hC, CODES[i]});
      chk8({4'h0, mux_select_field}, {4'h0, CODES[i]}, "mux code");
      flag(analog_monitor_out, MON[i], "monitor");
    end
    rd_c(8'h03, 8'hCC);
    $display("test select done");
    wr_c(8'h07, 8'h20);
    rd_c(8'h07, 8'h00);
    wr_c(8'h08, 8'h98);
    rd_c(8'h08, 8'h98);
    wr_c(8'h07, 8'h20);
    rd_c(8'h07, 8'h20);
    count_on(250, 250);
    wr_c(8'h07, 8'h80);
    count_on(250, 0);
    wr_c(8'h07, 8'h00);
    count_on(SCAN_P, SCAN_ON);
    wr_c(8'h07, 8'h40);
    flag(regulator_output, 1'b0, "regulator disabled");
    wr_c(8'h07, 8'h00);
    flag(regulator_output, 1'b1, "regulator enabled");
    $display("test feature done");
    @(posedge mclk);
    temp_below_ref <= 1'b1;
    wr_c(8'h07, 8'hA0);
    flag(ext_overtemp, 1'b1, "overtemp");
    wr_c(8'h07, 8'h80);
    flag(ext_overtemp, 1'b0, "overtemp, supply off");
    @(posedge mclk);
    temp_below_ref <= 1'b0;
    $display("test overtemp done");
    wr_c(8'h03, 8'h45);
    wr_c(8'h04, 8'h80);
    flag(sleep_state, 1'b1, "asleep");
    flag(regulator_output, 1'b0, "regulator asleep");
    flag(storage_from_cell, 1'b1, "storage on cell");
    chk8({4'h0, mux_select_field}, 8'h05, "mux kept");
    rd_c(8'h03, 8'h45);
    rd_c(8'h04, 8'h80);
    pin(1'b0);
    flag(sleep_state, 1'b0, "falling edge wake");
    flag(regulator_output, 1'b1, "regulator on");
    rd_c(8'h04, 8'h00);
    wr_c(8'h07, 8'h01);
    wr_c(8'h04, 8'h80);
    pin(1'b1);
    flag(sleep_state, 1'b0, "rising edge wake");
    wr_c(8'h04, 8'h80);
    pin(1'b0);
    flag(sleep_state, 1'b1, "falling edge ignored");
    wr_c(8'h07, 8'h03);
    pin(1'b1);
    flag(sleep_state, 1'b1, "wake pin disabled");
    wr_c(8'h04, 8'h00);
    flag(sleep_state, 1'b0, "woken by write");
    $display("test sleep done");
    wr_c(8'h07, 8'h04);
    foreach (OFFS[i]) rd_c(OFFS[i], 8'h00);
    wr_c(8'h07, 8'h20);
    rd_c(8'h07, 8'h00);
    $display("test force reset done");
    close_out();
  end
endmodule : tb_top
